// File: verilog/cid_decoder.sv
`timescale 1ns/1ps
// How it works
// - Add word or byte, optional carry-in, two or four bytes long.
// - Subtract word or byte, optional borrow from the carry flag.
// - Signed or unsigned 16x16 register multiply, two bytes.
// - Signed or unsigned divide of low product register by a register, two bytes.
// - Long divide of the 32-bit register pair by a 16-bit register, two bytes.
// - Complement and negate work in place on a word or byte register, two bytes.
// - Bit copy, optionally inverted, between direct bits, four bytes.
// - Masked write of high or low byte with immediate data, four bytes.
// - Compare with register then step it down or up by one or two.
// - Normalise count of one register written into another, two bytes.
// - Right shift that fills vacated bits with the sign, two bytes.
// - Byte to word move with sign or zero fill, two or four bytes.
// - Absolute, indirect, relative jumps taken only on met condition, four bytes.
// - Bit branch on set may clear the bit; on clear may set it.
// - Push a direct register then call absolute subroutine, four bytes.
// - Context switch pushes a register then loads it with a word.
// - Software trap enters routine picked by an immediate number, two bytes.
// - Return restores address and optionally pops a register, two bytes.
// - Power down entered only while the non-maskable pin is low, four bytes.
// - Cross-segment call may target any code segment.
// - Page prefix starts override sequence, optionally register too, two or four bytes.
module cid_decoder (
  input  wire logic                      i_clk,          // CPU clock, 125 MHz
  input  wire logic                      i_rst,          // Core reset, async, high
  input  wire logic                      i_vld,          // Instruction from fetch
  input  wire logic [7:0]                i_op,           // First byte
  input  wire logic [7:0]                i_op2,          // Second byte
  input  wire logic [3:0]                i_flags,        // Z, C, N, V
  input  wire logic                      i_bit,          // Tested direct bit
  input  wire logic                      i_nmi_n,        // Non-maskable pin level
  output logic                           o_dec_vld,      // Decode result valid
  output cid_pkg::cid_class_e            o_class,        // Instruction class
  output logic                           o_len4,         // 1: four bytes, 0: two
  output logic                           o_byte_op,      // Byte operand
  output logic                           o_with_carry,   // Carry or borrow used
  output logic                           o_unsigned,     // Unsigned mul or div
  output logic                           o_invert,       // Inverted bit copy
  output logic                           o_high_byte,    // Masked high byte
  output logic                           o_step_up,      // Step register upward
  output logic                           o_step_two,     // Step by two
  output logic                           o_zero_ext,     // Zero fill, else sign
  output logic [1:0]                     o_jump_kind,    // Abs, indirect, relative
  output logic                           o_taken,        // Branch taken
  output logic                           o_bit_write,    // Branch writes the bit
  output logic                           o_bit_value,    // Value written
  output logic                           o_push_reg,     // Push before action
  output logic                           o_pop_reg,      // Pop after return
  output logic                           o_any_seg,      // Segment from operand
  output logic                           o_ext_reg,      // Register extension too
  output logic                           o_power_down_entry_go,     // Enter power down
  output logic [7:0]                     o_trap_num,     // Trap number or operand
  output logic                           o_illegal       // Unknown operation
);

  // ---------------------------------------------------------------------------
  // Stage 1: class lookup and operand capture
  // ---------------------------------------------------------------------------
  logic [cid_pkg::ROM_W-1:0] rom_q;
  logic                      s1_vld_ff;
  logic [2:0]                s1_var_ff;
  logic [7:0]                s1_op2_ff;
  logic [3:0]                s1_flags_ff;
  logic                      s1_bit_ff;
  logic                      s1_nmi_low_ff;

  cid_class_rom #(
    .AW (5),
    .DW (cid_pkg::ROM_W)
  ) u_rom (
    .i_clk  (i_clk),
    .i_rst  (i_rst),
    .i_addr (i_op[7:3]),
    .o_data (rom_q)
  );

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s1_vld_ff     <= 1'b0;
      s1_var_ff     <= 3'h0;
      s1_op2_ff     <= 8'h00;
      s1_flags_ff   <= 4'h0;
      s1_bit_ff     <= 1'b0;
      s1_nmi_low_ff <= 1'b0;
    end else begin
      s1_vld_ff     <= i_vld;
      s1_var_ff     <= i_op[2:0];
      s1_op2_ff     <= i_op2;
      s1_flags_ff   <= i_flags;
      s1_bit_ff     <= i_bit;
      s1_nmi_low_ff <= !i_nmi_n;
    end
  end

  // ---------------------------------------------------------------------------
  // Stage 1 decode
  // ---------------------------------------------------------------------------
  cid_pkg::cid_class_e cls;
  logic [1:0]          len_code;
  logic                va;
  logic                vb;
  logic                vl;
  logic                taken;

  assign cls      = cid_pkg::cid_class_e'(rom_q[cid_pkg::ROM_W-1:2]);
  assign len_code = rom_q[1:0];
  assign va       = s1_var_ff[cid_pkg::VAR_A];
  assign vb       = s1_var_ff[cid_pkg::VAR_B];
  assign vl       = s1_var_ff[cid_pkg::VAR_LEN];

  function automatic logic is_cls(cid_pkg::cid_class_e c, cid_pkg::cid_class_e k);
    return c == k;
  endfunction

  // Fixed-length classes ignore the length variant bit.
  wire nxt_len4 = (len_code == cid_pkg::LEN_4) ||
                  ((len_code == cid_pkg::LEN_VAR) && vl);

  wire arith_cls  = is_cls(cls, cid_pkg::CID_ADD) || is_cls(cls, cid_pkg::CID_SUB);
  wire md_cls     = is_cls(cls, cid_pkg::CID_MUL) || is_cls(cls, cid_pkg::CID_DIV) ||
                    is_cls(cls, cid_pkg::CID_DIVL);
  wire inplace    = is_cls(cls, cid_pkg::CID_CPL) || is_cls(cls, cid_pkg::CID_NEG);
  wire jbit_cls   = is_cls(cls, cid_pkg::CID_JBIT);
  wire jmp_cls    = is_cls(cls, cid_pkg::CID_JMP);

  wire nxt_byte   = (arith_cls || inplace) && va;
  wire nxt_carry  = arith_cls && vb;
  wire nxt_uns    = md_cls && va;
  wire nxt_inv    = is_cls(cls, cid_pkg::CID_BITCOPY) && va;
  wire nxt_high   = is_cls(cls, cid_pkg::CID_BFLD) && va;
  wire nxt_up     = is_cls(cls, cid_pkg::CID_CMPSTEP) && va;
  wire nxt_two    = is_cls(cls, cid_pkg::CID_CMPSTEP) && vb;
  wire nxt_zero   = is_cls(cls, cid_pkg::CID_MOVEXT) && va;
  wire [1:0] nxt_jk = jmp_cls ? {vb, va} : 2'h0;
  // A bit branch only rewrites the bit when it is taken.
  wire nxt_bitwr  = jbit_cls && vb && taken;
  wire nxt_bitval = !va;
  wire nxt_push   = is_cls(cls, cid_pkg::CID_PUSH_THEN_CALL) ||
                    is_cls(cls, cid_pkg::CID_CONTEXT_SWITCH_OP);
  wire nxt_pop    = is_cls(cls, cid_pkg::CID_RET) && va;
  wire nxt_anyseg = is_cls(cls, cid_pkg::CID_CROSS_SEGMENT_CALL);
  wire nxt_extreg = is_cls(cls, cid_pkg::CID_EXTP) && va;
  // Power down is refused while the pin is high; the datapath sees a plain class.
  wire nxt_power_down_entry  = s1_vld_ff && is_cls(cls, cid_pkg::CID_POWER_DOWN_ENTRY) && s1_nmi_low_ff;

  cid_branch_eval u_branch (
    .i_jbit   (jbit_cls),
    .i_jcond  (jmp_cls),
    .i_on_set (va),
    .i_cc     (s1_op2_ff[3:0]),
    .i_flags  (s1_flags_ff),
    .i_bit    (s1_bit_ff),
    .o_taken  (taken)
  );

  // ---------------------------------------------------------------------------
  // Stage 2: registered decode outputs
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_dec_vld    <= 1'b0;
      o_class      <= cid_pkg::CID_ADD;
      o_len4       <= 1'b0;
      o_byte_op    <= 1'b0;
      o_with_carry <= 1'b0;
      o_unsigned   <= 1'b0;
      o_invert     <= 1'b0;
      o_high_byte  <= 1'b0;
      o_step_up    <= 1'b0;
      o_step_two   <= 1'b0;
      o_zero_ext   <= 1'b0;
      o_jump_kind  <= 2'h0;
      o_taken      <= 1'b0;
      o_bit_write  <= 1'b0;
      o_bit_value  <= 1'b0;
      o_push_reg   <= 1'b0;
      o_pop_reg    <= 1'b0;
      o_any_seg    <= 1'b0;
      o_ext_reg    <= 1'b0;
      o_power_down_entry_go   <= 1'b0;
      o_trap_num   <= 8'h00;
      o_illegal    <= 1'b0;
    end else begin
      o_dec_vld    <= s1_vld_ff;
      o_class      <= cls;
      o_len4       <= nxt_len4;
      o_byte_op    <= nxt_byte;
      o_with_carry <= nxt_carry;
      o_unsigned   <= nxt_uns;
      o_invert     <= nxt_inv;
      o_high_byte  <= nxt_high;
      o_step_up    <= nxt_up;
      o_step_two   <= nxt_two;
      o_zero_ext   <= nxt_zero;
      o_jump_kind  <= nxt_jk;
      o_taken      <= taken;
      o_bit_write  <= nxt_bitwr;
      o_bit_value  <= nxt_bitval;
      o_push_reg   <= nxt_push;
      o_pop_reg    <= nxt_pop;
      o_any_seg    <= nxt_anyseg;
      o_ext_reg    <= nxt_extreg;
      o_power_down_entry_go   <= nxt_power_down_entry;
      o_trap_num   <= s1_op2_ff;
      o_illegal    <= s1_vld_ff && is_cls(cls, cid_pkg::CID_ILLEGAL);
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  wire out_add  = o_dec_vld && (o_class == cid_pkg::CID_ADD);
  wire out_mdiv = o_dec_vld && ((o_class == cid_pkg::CID_MUL) ||
                  (o_class == cid_pkg::CID_DIV) || (o_class == cid_pkg::CID_DIVL));

  sequence req_s(logic [4:0] opc);
    i_vld && (i_op[7:3] == opc);
  endsequence

  pipe_valid_a:   assert property (i_vld |-> ##2 o_dec_vld)
    else $error("Decode result missing two cycles after request");
  add_len_a:      assert property (req_s(cid_pkg::OPC_ADD) |-> ##2
                    (o_len4 == $past(i_op[2], 2)) && (o_with_carry == $past(i_op[1], 2)))
    else $error("Add length or carry variant wrong");
  sub_byte_a:     assert property (req_s(cid_pkg::OPC_SUB) |-> ##2
                    (o_class == cid_pkg::CID_SUB) && (o_byte_op == $past(i_op[0], 2)))
    else $error("Subtract class or byte variant wrong");
  mul_div_len_a:  assert property (out_mdiv |-> !o_len4 && !o_byte_op)
    else $error("Multiply or divide not two bytes long");
  copy_invert_a:  assert property (req_s(cid_pkg::OPC_BITCOPY) |-> ##2
                    o_len4 && (o_invert == $past(i_op[0], 2)))
    else $error("Bit copy length or inversion wrong");
  step_size_a:    assert property (req_s(cid_pkg::OPC_CMPSTEP) |-> ##2
                    (o_step_two == $past(i_op[1], 2)) && (o_step_up == $past(i_op[0], 2)))
    else $error("Compare step size or direction wrong");
  jump_cond_a:    assert property (req_s(cid_pkg::OPC_JMP) && (i_op2[3:0] == cid_pkg::CC_Z)
                    |-> ##2 o_len4 && (o_taken == $past(i_flags[cid_pkg::FLG_Z], 2)))
    else $error("Conditional jump taken against its condition");
  bit_branch_a:   assert property (o_bit_write |->
                    (o_class == cid_pkg::CID_JBIT) && o_taken)
    else $error("Bit rewritten by an untaken branch");
  power_down_entry_gate_a:   assert property (req_s(cid_pkg::OPC_POWER_DOWN_ENTRY) |-> ##2
                    (o_power_down_entry_go == !$past(i_nmi_n, 2)) && o_len4)
    else $error("Power down entered with the pin high");
  ret_pop_a:      assert property (req_s(cid_pkg::OPC_RET) |-> ##2
                    !o_len4 && (o_pop_reg == $past(i_op[0], 2)))
    else $error("Return length or pop variant wrong");
  add_only_a:     assert property (out_add |-> !o_unsigned && !o_push_reg)
    else $error("Add carries foreign attributes");

endmodule // cid_decoder

// File: verilog/cid_pkg.sv
package cid_pkg;

  // ---------------------------------------------------------------------------
  // Instruction classes seen by the execution datapath
  // ---------------------------------------------------------------------------
  typedef enum logic [4:0] {
    CID_ADD, CID_SUB, CID_MUL, CID_DIV, CID_DIVL, CID_CPL, CID_NEG,
    CID_BITCOPY, CID_BFLD, CID_CMPSTEP, CID_NORMALISE_COUNT, CID_SIGN_FILL_RIGHT_SHIFT, CID_MOVEXT,
    CID_JMP, CID_JBIT, CID_PUSH_THEN_CALL, CID_CROSS_SEGMENT_CALL, CID_CONTEXT_SWITCH_OP, CID_TRAP, CID_RET,
    CID_POWER_DOWN_ENTRY, CID_EXTP, CID_ILLEGAL
  } cid_class_e;

  // ---------------------------------------------------------------------------
  // Operation field of the first instruction byte, bits 7..3
  // ---------------------------------------------------------------------------
  localparam logic [4:0] OPC_ADD     = 5'h00;
  localparam logic [4:0] OPC_SUB     = 5'h01;
  localparam logic [4:0] OPC_MUL     = 5'h02;
  localparam logic [4:0] OPC_DIV     = 5'h03;
  localparam logic [4:0] OPC_DIVL    = 5'h04;
  localparam logic [4:0] OPC_CPL     = 5'h05;
  localparam logic [4:0] OPC_NEG     = 5'h06;
  localparam logic [4:0] OPC_BITCOPY = 5'h07;
  localparam logic [4:0] OPC_BFLD    = 5'h08;
  localparam logic [4:0] OPC_CMPSTEP = 5'h09;
  localparam logic [4:0] OPC_NORMALISE_COUNT   = 5'h0a;
  localparam logic [4:0] OPC_SIGN_FILL_RIGHT_SHIFT    = 5'h0b;
  localparam logic [4:0] OPC_MOVEXT  = 5'h0c;
  localparam logic [4:0] OPC_JMP     = 5'h0d;
  localparam logic [4:0] OPC_JBIT    = 5'h0e;
  localparam logic [4:0] OPC_PUSH_THEN_CALL   = 5'h0f;
  localparam logic [4:0] OPC_CROSS_SEGMENT_CALL   = 5'h10;
  localparam logic [4:0] OPC_CONTEXT_SWITCH_OP    = 5'h11;
  localparam logic [4:0] OPC_TRAP    = 5'h12;
  localparam logic [4:0] OPC_RET     = 5'h13;
  localparam logic [4:0] OPC_POWER_DOWN_ENTRY   = 5'h14;
  localparam logic [4:0] OPC_EXTP    = 5'h15;

  // ---------------------------------------------------------------------------
  // Length codes stored in the class table, and variant bit positions
  // ---------------------------------------------------------------------------
  localparam logic [1:0] LEN_2   = 2'h0;
  localparam logic [1:0] LEN_4   = 2'h1;
  localparam logic [1:0] LEN_VAR = 2'h2;
  localparam int         VAR_A   = 0;
  localparam int         VAR_B   = 1;
  localparam int         VAR_LEN = 2;

  // ---------------------------------------------------------------------------
  // Branch condition codes, second byte bits 3..0
  // ---------------------------------------------------------------------------
  localparam logic [3:0] CC_UC  = 4'h0;
  localparam logic [3:0] CC_Z   = 4'h1;
  localparam logic [3:0] CC_NZ  = 4'h2;
  localparam logic [3:0] CC_C   = 4'h3;
  localparam logic [3:0] CC_NC  = 4'h4;
  localparam logic [3:0] CC_N   = 4'h5;
  localparam logic [3:0] CC_NN  = 4'h6;
  localparam logic [3:0] CC_V   = 4'h7;
  localparam logic [3:0] CC_NV  = 4'h8;
  localparam int         FLG_Z  = 0;
  localparam int         FLG_C  = 1;
  localparam int         FLG_N  = 2;
  localparam int         FLG_V  = 3;

  localparam int         ROM_W  = 7;
  localparam logic [6:0] ROM_RESET = 7'h00;
  localparam int         PIPE_DEPTH = 2;

endpackage

// File: verilog/cid_class_rom.sv
`timescale 1ns/1ps
module cid_class_rom #(
  parameter int AW = 5,
  parameter int DW = cid_pkg::ROM_W
) (
  input  wire logic          i_clk,   // CPU clock
  input  wire logic          i_rst,   // Core reset
  input  wire logic [AW-1:0] i_addr,  // Operation field
  output logic      [DW-1:0] o_data   // {class, length code}, registered
);

  // ---------------------------------------------------------------------------
  // Table of classes and lengths
  // ---------------------------------------------------------------------------
  function automatic logic [DW-1:0] ent(cid_pkg::cid_class_e c, logic [1:0] l);
    return {c, l};
  endfunction

  logic [DW-1:0] rd_data;

  always_comb begin
    unique case (i_addr)
      cid_pkg::OPC_ADD:     rd_data = ent(cid_pkg::CID_ADD, cid_pkg::LEN_VAR);
      cid_pkg::OPC_SUB:     rd_data = ent(cid_pkg::CID_SUB, cid_pkg::LEN_VAR);
      cid_pkg::OPC_MUL:     rd_data = ent(cid_pkg::CID_MUL, cid_pkg::LEN_2);
      cid_pkg::OPC_DIV:     rd_data = ent(cid_pkg::CID_DIV, cid_pkg::LEN_2);
      cid_pkg::OPC_DIVL:    rd_data = ent(cid_pkg::CID_DIVL, cid_pkg::LEN_2);
      cid_pkg::OPC_CPL:     rd_data = ent(cid_pkg::CID_CPL, cid_pkg::LEN_2);
      cid_pkg::OPC_NEG:     rd_data = ent(cid_pkg::CID_NEG, cid_pkg::LEN_2);
      cid_pkg::OPC_BITCOPY: rd_data = ent(cid_pkg::CID_BITCOPY, cid_pkg::LEN_4);
      cid_pkg::OPC_BFLD:    rd_data = ent(cid_pkg::CID_BFLD, cid_pkg::LEN_4);
      cid_pkg::OPC_CMPSTEP: rd_data = ent(cid_pkg::CID_CMPSTEP, cid_pkg::LEN_VAR);
      cid_pkg::OPC_NORMALISE_COUNT:   rd_data = ent(cid_pkg::CID_NORMALISE_COUNT, cid_pkg::LEN_2);
      cid_pkg::OPC_SIGN_FILL_RIGHT_SHIFT:    rd_data = ent(cid_pkg::CID_SIGN_FILL_RIGHT_SHIFT, cid_pkg::LEN_2);
      cid_pkg::OPC_MOVEXT:  rd_data = ent(cid_pkg::CID_MOVEXT, cid_pkg::LEN_VAR);
      cid_pkg::OPC_JMP:     rd_data = ent(cid_pkg::CID_JMP, cid_pkg::LEN_4);
      cid_pkg::OPC_JBIT:    rd_data = ent(cid_pkg::CID_JBIT, cid_pkg::LEN_4);
      cid_pkg::OPC_PUSH_THEN_CALL:   rd_data = ent(cid_pkg::CID_PUSH_THEN_CALL, cid_pkg::LEN_4);
      cid_pkg::OPC_CROSS_SEGMENT_CALL:   rd_data = ent(cid_pkg::CID_CROSS_SEGMENT_CALL, cid_pkg::LEN_4);
      cid_pkg::OPC_CONTEXT_SWITCH_OP:    rd_data = ent(cid_pkg::CID_CONTEXT_SWITCH_OP, cid_pkg::LEN_4);
      cid_pkg::OPC_TRAP:    rd_data = ent(cid_pkg::CID_TRAP, cid_pkg::LEN_2);
      cid_pkg::OPC_RET:     rd_data = ent(cid_pkg::CID_RET, cid_pkg::LEN_2);
      cid_pkg::OPC_POWER_DOWN_ENTRY:   rd_data = ent(cid_pkg::CID_POWER_DOWN_ENTRY, cid_pkg::LEN_4);
      cid_pkg::OPC_EXTP:    rd_data = ent(cid_pkg::CID_EXTP, cid_pkg::LEN_VAR);
      default:              rd_data = ent(cid_pkg::CID_ILLEGAL, cid_pkg::LEN_2);
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_data <= cid_pkg::ROM_RESET;
    end else begin
      o_data <= rd_data;
    end
  end

endmodule // cid_class_rom

// File: verilog/cid_branch_eval.sv
`timescale 1ns/1ps
module cid_branch_eval (
  input  wire logic               i_jbit,   // Bit-test branch in flight
  input  wire logic               i_jcond,  // Conditional branch in flight
  input  wire logic               i_on_set, // Bit-test form branches on set
  input  wire logic [3:0]         i_cc,     // Condition code
  input  wire logic [3:0]         i_flags,  // Z, C, N, V from the datapath
  input  wire logic               i_bit,    // Value of the tested bit
  output logic                    o_taken   // Branch is taken
);

  // ---------------------------------------------------------------------------
  // Condition match
  // ---------------------------------------------------------------------------
  logic cc_met;

  always_comb begin
    unique case (i_cc)
      cid_pkg::CC_UC: cc_met = 1'b1;
      cid_pkg::CC_Z:  cc_met = i_flags[cid_pkg::FLG_Z];
      cid_pkg::CC_NZ: cc_met = !i_flags[cid_pkg::FLG_Z];
      cid_pkg::CC_C:  cc_met = i_flags[cid_pkg::FLG_C];
      cid_pkg::CC_NC: cc_met = !i_flags[cid_pkg::FLG_C];
      cid_pkg::CC_N:  cc_met = i_flags[cid_pkg::FLG_N];
      cid_pkg::CC_NN: cc_met = !i_flags[cid_pkg::FLG_N];
      cid_pkg::CC_V:  cc_met = i_flags[cid_pkg::FLG_V];
      cid_pkg::CC_NV: cc_met = !i_flags[cid_pkg::FLG_V];
      default:        cc_met = 1'b0;
    endcase
  end

  assign o_taken = (i_jcond && cc_met) || (i_jbit && (i_bit == i_on_set));

endmodule // cid_branch_eval

// File: dv/cid_fetch_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Fetch stage model.
// ---------------------------------------------------------------
module cid_fetch_model (
  input  wire logic       i_clk,    // CPU clock
  output logic            o_vld,    // Request valid
  output logic [7:0]      o_op,     // First byte
  output logic [7:0]      o_op2,    // Second byte
  output logic [3:0]      o_flags,  // V, N, C, Z
  output logic            o_bit,    // Tested direct bit
  output logic            o_nmi_n   // Non-maskable pin level
);
  initial begin
    o_vld = 1'b0;
    o_op = 8'h00;
    o_op2 = 8'h00;
    o_flags = 4'h0;
    o_bit = 1'b0;
    o_nmi_n = 1'b1;
  end
  task automatic issue(input logic [7:0] op, input logic [7:0] op2, input logic [3:0] fl,
                       input logic bt, input logic nmi_n);
    @(negedge i_clk);
    o_vld = 1'b1;
    o_op = op;
    o_op2 = op2;
    o_flags = fl;
    o_bit = bt;
    o_nmi_n = nmi_n;
  endtask
  // Released bytes are inverted so that a late read by the decoder is caught.
  task automatic idle();
    @(negedge i_clk);
    o_vld = 1'b0;
    o_op = ~o_op;
    o_op2 = ~o_op2;
    o_flags = ~o_flags;
    o_bit = ~o_bit;
  endtask
endmodule // cid_fetch_model

// File: dv/tb_cid_decoder.sv
`timescale 1ns/1ps
module tb_cid_decoder;
  logic i_clk, i_rst, i_vld, i_bit, i_nmi_n, o_dec_vld, o_len4, o_byte_op, o_with_carry;
  logic o_unsigned, o_invert, o_high_byte, o_step_up, o_step_two, o_zero_ext, o_taken;
  logic o_bit_write, o_bit_value, o_push_reg, o_pop_reg, o_any_seg, o_ext_reg, o_power_down_entry_go;
  logic o_illegal;
  logic [7:0] i_op, i_op2, o_trap_num;
  logic [3:0] i_flags;
  logic [1:0] o_jump_kind;
  cid_pkg::cid_class_e o_class;
  int err_total = 0;
  int n_tests = 0;
  int cycles = 0;
  // Attribute outputs expected with variant bits A and B both set, per operation field.
  localparam logic [13:0] MASK [22] = '{14'h3000, 14'h3000, 14'h0800, 14'h0800, 14'h0800,
    14'h2000, 14'h2000, 14'h0400, 14'h0200, 14'h0180, 14'h0000, 14'h0000, 14'h0040,
    14'h0003, 14'h0000, 14'h0008, 14'h0004, 14'h0008, 14'h0000, 14'h0020, 14'h0000, 14'h0010};
  wire [13:0] attr = {o_byte_op, o_with_carry, o_unsigned, o_invert, o_high_byte, o_step_up,
    o_step_two, o_zero_ext, o_pop_reg, o_ext_reg, o_push_reg, o_any_seg, o_jump_kind};
  cid_fetch_model u_fetch (.i_clk, .o_vld(i_vld), .o_op(i_op), .o_op2(i_op2),
    .o_flags(i_flags), .o_bit(i_bit), .o_nmi_n(i_nmi_n));
  cid_decoder dut (.i_clk, .i_rst, .i_vld, .i_op, .i_op2, .i_flags, .i_bit, .i_nmi_n,
    .o_dec_vld, .o_class, .o_len4, .o_byte_op, .o_with_carry, .o_unsigned, .o_invert,
    .o_high_byte, .o_step_up, .o_step_two, .o_zero_ext, .o_jump_kind, .o_taken,
    .o_bit_write, .o_bit_value, .o_push_reg, .o_pop_reg, .o_any_seg, .o_ext_reg,
    .o_power_down_entry_go, .o_trap_num, .o_illegal);
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  task automatic stop_test();
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      stop_test();
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic cond(input logic [3:0] cc, input logic [3:0] fl);
    case (cc)
      4'h0: cond = 1'b1;
      4'h1, 4'h2: cond = fl[cid_pkg::FLG_Z] ^ cc[1];
      4'h3, 4'h4: cond = fl[cid_pkg::FLG_C] ^ cc[2];
      4'h5, 4'h6: cond = fl[cid_pkg::FLG_N] ^ cc[1];
      4'h7, 4'h8: cond = fl[cid_pkg::FLG_V] ^ cc[3];
      default: cond = 1'b0;
    endcase
  endfunction
  // The result of a lone request is looked at in its single valid cycle.
  task automatic run(input logic [7:0] op, input logic [7:0] op2 = 8'h00,
                     input logic [3:0] fl = 4'h0, input logic bt = 1'b0, input logic nm = 1'b1);
    u_fetch.issue(op, op2, fl, bt, nm);
    u_fetch.idle();
    @(negedge i_clk);
    chk(o_dec_vld, 1'b1);
  endtask
  task automatic t_map();
    logic [4:0] f;
    logic il;
    for (int k = 0; k < 128; k++) begin
      f = 5'(k / 4);
      il = f > 5'h15;
      run({f, k[1], k[0], k[0]});
      chk(o_len4, (f inside {7, 8, 13, 14, 15, 16, 17, 20}) | (k[1] & (f inside {0, 1, 9, 12, 21})));
      chk({o_illegal, 2'h0, o_class}, il ? {3'h4, 5'(cid_pkg::CID_ILLEGAL)} : 8'(f));
      chk(attr, il ? 14'h0000 : MASK[f] & (k[0] ? 14'h3fff : 14'h000c));
    end
  endtask
  task automatic t_branch();
    logic [3:0] fl;
    for (int i = 0; i < 32; i++) begin
      fl = i < 16 ? 4'h5 : 4'ha;
      run({cid_pkg::OPC_JMP, 3'h4}, 8'(i * 17), fl);
      chk(o_taken, cond(4'(i), fl));
    end
    for (int i = 0; i < 8; i++) begin
      run({cid_pkg::OPC_JBIT, 3'(i)}, 8'h00, 4'h0, i[2]);
      chk({o_taken, o_bit_write, o_bit_value}, {i[2] == i[0], i[1] & (i[2] == i[0]), !i[0]});
    end
  endtask
  task automatic t_misc();
    for (int i = 0; i < 2; i++) begin
      run({cid_pkg::OPC_POWER_DOWN_ENTRY, 3'h0}, 8'h00, 4'h0, 1'b0, i[0]);
      chk(o_power_down_entry_go, !i[0]);
      run({cid_pkg::OPC_TRAP, 3'h0}, 8'h5a ^ 8'(i * 255), 4'h0, 1'b0, 1'b0);
      chk({o_trap_num, o_power_down_entry_go}, {8'h5a ^ 8'(i * 255), 1'b0});
    end
    u_fetch.issue({cid_pkg::OPC_POWER_DOWN_ENTRY, 3'h0}, 8'h00, 4'h0, 1'b0, 1'b0);
    u_fetch.issue({cid_pkg::OPC_CROSS_SEGMENT_CALL, 3'h0}, 8'h00, 4'h0, 1'b0, 1'b1);
    u_fetch.idle();
    chk({o_dec_vld, o_power_down_entry_go, o_len4}, 3'h7);
    @(negedge i_clk);
    chk({o_dec_vld, o_power_down_entry_go, o_any_seg, o_class}, {3'h5, cid_pkg::CID_CROSS_SEGMENT_CALL});
    @(negedge i_clk);
    chk(o_dec_vld, 1'b0);
  endtask
  initial begin
    i_rst = 1'b1;
    repeat (6) @(negedge i_clk);
    chk({o_dec_vld, o_class}, 6'h00);
    i_rst = 1'b0;
    t_map();
    t_branch();
    t_misc();
    stop_test();
  end
endmodule // tb_cid_decoder
